// File: rcf_defs.svh
// reset-cause flag register: offsets, bit positions, reset values
// assumes byte addresses on a 32-bit apb; included by bare name
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH

// register byte offsets
`define RCF_OFS_FLAGS 12'h000
`define RCF_OFS_EVT_STATUS 12'h004
`define RCF_OFS_EVT_MASK 12'h008

// flag bit positions
`define RCF_BIT_INTERRUPT_PRIORITY_ENABLE 7
`define RCF_BIT_SOFT 4
`define RCF_BIT_DOG 3
`define RCF_BIT_SLEEP 2
`define RCF_BIT_POR 1
`define RCF_BIT_BOR 0

// writable flag bits and power-on value without the brown-out bit
`define RCF_FLAGS_WMASK 8'h9F
`define RCF_FLAGS_POR_VAL 8'h1C

// event status bits, one per event source
`define RCF_NUM_EVENTS 5
`define RCF_EVT_RESET_VAL 5'h00

`endif

// File: rcf_pkg.sv
// types shared by the reset-cause flag register
// assumes rcf_defs.svh carries the numeric constants
package rcf_pkg;
   // device events that steer the flags, each a one-cycle pulse
   typedef struct packed {
      logic soft_reset;          // reset instruction executed
      logic dog_expiry;          // watchdog_timer time-out reset
      logic sleep_instr;         // sleep instruction executed
      logic watchdog_clear_instr; // watchdog clear executed
      logic brownout;            // brown-out reset
   } rcf_event_t;

   // apb slave phase
   typedef enum logic [1:0] {
      RCF_IDLE = 2'b01,
      RCF_ANSWER = 2'b10
   } rcf_phase_t;
endpackage

// File: rcf_evt_irq.sv
// sticky event status with write-one-to-clear, mask and irq level
// assumes set pulses and bus strobes synchronous to i_clock
`timescale 1ns/1ps
`include "rcf_defs.svh"
module rcf_evt_irq #(
   parameter int N = `RCF_NUM_EVENTS
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [N-1:0] i_set,
   input wire logic i_clr_we,
   input wire logic [N-1:0] i_clr_bits,
   input wire logic i_mask_we,
   input wire logic [N-1:0] i_mask_wdata,
   output logic [N-1:0] o_status,
   output logic [N-1:0] o_mask,
   output logic o_irq
);
   logic [N-1:0] status_reg, status_next;
   logic [N-1:0] mask_reg, mask_next;
   logic irq_reg, irq_next;

   // per bit: a set in the clearing cycle wins over the clear
   genvar g;
   for (g = 0; g < N; g++) begin : g_bit
      always_comb begin
         status_next[g] = status_reg[g];
         if (i_clr_we && i_clr_bits[g]) status_next[g] = 1'b0;
         if (i_set[g]) status_next[g] = 1'b1;
      end
   end

   // next mask from a write, irq level from the next status and next mask
   always_comb begin
      mask_next = i_mask_we ? i_mask_wdata : mask_reg;
      irq_next = |(status_next & mask_next);
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         status_reg <= N'(`RCF_EVT_RESET_VAL);
         mask_reg <= N'(`RCF_EVT_RESET_VAL);
         irq_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         mask_reg <= mask_next;
         irq_reg <= irq_next;
      end
   end

   assign o_status = status_reg;
   assign o_mask = mask_reg;
   assign o_irq = irq_reg;
endmodule // rcf_evt_irq

// File: rcf_regs.sv
// reset-cause flag register with apb slave and event interrupt
// assumes i_rst is the power-on reset; other reset causes arrive
// as one-cycle event pulses while this block keeps running
`timescale 1ns/1ps
`include "rcf_defs.svh"
module rcf_regs (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire rcf_pkg::rcf_event_t i_event,
   input wire logic i_brownout_enable_fuse,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_interrupt_priority_enable,
   output logic o_irq
);
   import rcf_pkg::*;

   localparam int NEV = `RCF_NUM_EVENTS;

   rcf_phase_t phase_reg, phase_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [7:0] flags_reg, flags_next;
   logic [NEV-1:0] evt_status, evt_mask, evt_set;
   logic acc, commit, hit_flags, hit_status, hit_mask, mapped;
   logic wr_flags, wr_status, wr_mask, any_reset_evt;
   logic irq_w;

   // address decode and the commit edge of an access
   always_comb begin
      acc = i_psel && i_penable;
      commit = acc && pready_reg;
      hit_flags = (i_paddr == `RCF_OFS_FLAGS);
      hit_status = (i_paddr == `RCF_OFS_EVT_STATUS);
      hit_mask = (i_paddr == `RCF_OFS_EVT_MASK);
      mapped = hit_flags || hit_status || hit_mask;
      wr_flags = commit && i_pwrite && hit_flags;
      wr_status = commit && i_pwrite && hit_status;
      wr_mask = commit && i_pwrite && hit_mask;
   end

   // apb phase: one wait cycle, then pready with data and error
   always_comb begin
      phase_next = phase_reg;
      pready_next = 1'b0;
      pslverr_next = 1'b0;
      prdata_next = 32'h00000000;
      unique case (phase_reg)
         RCF_IDLE: begin
            if (acc) begin
               phase_next = RCF_ANSWER;
               pready_next = 1'b1;
               pslverr_next = !mapped;
               if (!i_pwrite) begin
                  if (hit_flags) begin
                     // unimplemented bits read zero
                     prdata_next = {24'h000000,
                        flags_reg & `RCF_FLAGS_WMASK};
                  end else if (hit_status) begin
                     prdata_next = {{(32 - NEV){1'b0}}, evt_status};
                  end else if (hit_mask) begin
                     prdata_next = {{(32 - NEV){1'b0}}, evt_mask};
                  end
               end
            end
         end
         RCF_ANSWER: begin
            phase_next = RCF_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         phase_reg <= RCF_IDLE;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         phase_reg <= phase_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
         prdata_reg <= prdata_next;
      end
   end

   // flag update: software write first, hardware events override
   always_comb begin
      any_reset_evt = i_event.soft_reset || i_event.dog_expiry ||
         i_event.brownout;
      flags_next = flags_reg;
      if (wr_flags) begin
         flags_next = i_pwdata[7:0] & `RCF_FLAGS_WMASK;
      end
      if (i_event.watchdog_clear_instr) begin
         flags_next[`RCF_BIT_DOG] = 1'b1;
         flags_next[`RCF_BIT_SLEEP] = 1'b1;
      end
      if (i_event.sleep_instr) begin
         flags_next[`RCF_BIT_DOG] = 1'b1;
         flags_next[`RCF_BIT_SLEEP] = 1'b0;
      end
      if (i_event.dog_expiry) begin
         flags_next[`RCF_BIT_DOG] = 1'b0;
      end
      if (i_event.soft_reset) begin
         flags_next[`RCF_BIT_SOFT] = 1'b0;
      end
      if (i_event.brownout) begin
         flags_next[`RCF_BIT_BOR] = 1'b0;
      end
      // device resets drop back to legacy interrupt mode
      if (any_reset_evt) begin
         flags_next[`RCF_BIT_INTERRUPT_PRIORITY_ENABLE] = 1'b0;
      end
   end

   // power-on: fixed pattern, brown-out bit from the fuse
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         flags_reg <= `RCF_FLAGS_POR_VAL;
         flags_reg[`RCF_BIT_BOR] <= i_brownout_enable_fuse;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // event sources in status bit order
   assign evt_set = {i_event.soft_reset, i_event.dog_expiry,
      i_event.sleep_instr, i_event.watchdog_clear_instr,
      i_event.brownout};

   // sticky event status, mask and interrupt level
   rcf_evt_irq #(
      .N(NEV)
   ) u_evt (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_set(evt_set),
      .i_clr_we(wr_status),
      .i_clr_bits(i_pwdata[NEV-1:0]),
      .i_mask_we(wr_mask),
      .i_mask_wdata(i_pwdata[NEV-1:0]),
      .o_status(evt_status),
      .o_mask(evt_mask),
      .o_irq(irq_w)
   );

   // outputs straight from flops
   assign o_prdata = prdata_reg;
   assign o_pready = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_interrupt_priority_enable = flags_reg[`RCF_BIT_INTERRUPT_PRIORITY_ENABLE];
   assign o_irq = irq_w;

   // helper: reset seen in the previous cycle
   logic rst_d_reg;
   always_ff @(posedge i_clock) begin
      rst_d_reg <= i_rst;
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // a read of the flags shows unimplemented bits as zero
   a_unimpl_read_zero: assert property (
      (acc && !pready_reg && !i_pwrite && hit_flags)
      |=> o_pready && (o_prdata[6:5] == 2'b00))
      else $error("flags read shows nonzero unimplemented bits");

   // the write lands at the commit edge when no event competes
   a_flags_write: assert property (
      (wr_flags && !(|evt_set))
      |=> flags_reg == ($past(i_pwdata[7:0]) & 8'h9F))
      else $error("flags write not stored");

   // reset instruction clears its flag and priority enable
   a_soft_reset_flag: assert property (
      i_event.soft_reset |=> !flags_reg[4]
      && !o_interrupt_priority_enable)
      else $error("reset instruction flag not cleared");

   // watchdog expiry clears its flag, whatever else happens
   a_dog_expiry_clear: assert property (
      i_event.dog_expiry |=> !flags_reg[3])
      else $error("watchdog expiry flag not cleared");

   // sleep sets the expiry flag and clears the sleep flag
   a_sleep_entry: assert property (
      (i_event.sleep_instr && !i_event.dog_expiry)
      |=> flags_reg[3] && !flags_reg[2])
      else $error("sleep entry flags wrong");

   // watchdog clear alone sets both flags
   a_wdt_clear_sets: assert property (
      (i_event.watchdog_clear_instr && !i_event.sleep_instr &&
      !i_event.dog_expiry) |=> flags_reg[3] && flags_reg[2])
      else $error("watchdog clear did not set flags");

   // brown-out clears its flag and it is still low one cycle later when no write comes in between
   a_brownout_clear: assert property (
      (i_event.brownout ##1 !wr_flags) |=> !flags_reg[0])
      else $error("brown-out flag not held cleared");

   // after power-on the pattern and fuse value are in place
   a_por_values: assert property (
      rst_d_reg |-> !flags_reg[1] && flags_reg[4] && flags_reg[3]
      && flags_reg[2] && !flags_reg[7]
      && flags_reg[0] == $past(i_brownout_enable_fuse))
      else $error("power-on flag pattern wrong");

   // without event or write, the flags do not move
   a_flags_hold: assert property (
      (!wr_flags && !(|evt_set)) |=> $stable(flags_reg))
      else $error("flags changed without cause");

   // irq is high exactly while an unmasked status bit is set
   a_irq_level: assert property (
      o_irq == |(evt_status & evt_mask))
      else $error("irq level disagrees with status and mask");

   // an unmapped access answers with an error and zero data
   a_unmapped_refused: assert property (
      (acc && !pready_reg && !mapped)
      |=> o_pready && o_pslverr && (o_prdata == 32'h00000000))
      else $error("unmapped access not refused");

   // a mapped access answers without error
   a_mapped_no_error: assert property (
      (acc && !pready_reg && mapped) |=> o_pready && !o_pslverr)
      else $error("mapped access answered with error");

   // a flags read returns the register as it stood when taken
   a_flags_read_data: assert property (
      (acc && !pready_reg && !i_pwrite && hit_flags)
      |=> o_prdata == {24'h000000, $past(flags_reg)})
      else $error("flags read data wrong");

   // pready stands for one cycle only
   a_pready_pulse: assert property (
      o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");

   // read data is zero outside the answer cycle
   a_prdata_idle_zero: assert property (
      !o_pready |-> o_prdata == 32'h00000000)
      else $error("read data shown outside answer cycle");

   // watchdog expiry and brown-out drop the priority enable
   a_interrupt_priority_enable_reset_event: assert property (
      (i_event.dog_expiry || i_event.brownout)
      |=> !o_interrupt_priority_enable)
      else $error("priority enable kept across device reset");

   // only a software write raises the priority enable
   a_interrupt_priority_enable_no_rise: assert property (
      !wr_flags |=> !$rose(o_interrupt_priority_enable))
      else $error("priority enable rose without a write");

   // only a software write raises the reset instruction flag
   a_soft_flag_rise: assert property (
      !wr_flags |=> !$rose(flags_reg[4]))
      else $error("reset instruction flag rose without a write");

   // the power-on flag moves only by a software write
   a_por_flag_hold: assert property (
      !wr_flags |=> $stable(flags_reg[1]))
      else $error("power-on flag changed without a write");

   // brown-out clears its flag at once, even against a write
   a_brownout_now: assert property (
      i_event.brownout |=> !flags_reg[0])
      else $error("brown-out flag not cleared at once");

   // only a software write raises the brown-out flag
   a_brownout_no_rise: assert property (
      !wr_flags |=> !$rose(flags_reg[0]))
      else $error("brown-out flag rose without a write");

   // each event leaves its status bit set
   a_status_sticky: assert property (
      (|evt_set)
      |=> (evt_status & $past(evt_set)) == $past(evt_set))
      else $error("event status bit not set by its event");

   // a write of ones clears those status bits when no event competes
   a_status_w1c: assert property (
      (wr_status && !(|evt_set))
      |=> (evt_status & $past(i_pwdata[NEV-1:0])) == {NEV{1'b0}})
      else $error("status bits not cleared by write of ones");

   // a mask write stores the written bits
   a_mask_write: assert property (
      wr_mask |=> evt_mask == $past(i_pwdata[NEV-1:0]))
      else $error("mask write not stored");

   c_soft_reset: cover property (i_event.soft_reset ##1 wr_flags);
   c_sleep_then_clear: cover property (
      i_event.sleep_instr ##[1:20] i_event.watchdog_clear_instr);
   c_brownout: cover property (i_event.brownout);
   c_irq_rise: cover property ($rose(o_irq));
   c_unmapped: cover property (o_pready && o_pslverr);
endmodule // rcf_regs

// File: rcf_tb.sv
// self-checking bench for the reset-cause flag register
// assumes rcf_regs answers apb with pready and events as pulses
`timescale 1ns/1ps
`include "rcf_defs.svh"
module testbench;
   import rcf_pkg::*;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0;
   rcf_event_t i_event = rcf_event_t'(5'h00);
   logic i_brownout_enable_fuse = 1'b1;
   logic [31:0] o_prdata;
   logic o_pready, o_pslverr, o_interrupt_priority_enable, o_irq;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic err;
   logic [4:0] ev_tab [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h0E};
   logic [7:0] pre_tab [6] = '{8'h9F, 8'h9F, 8'h9F, 8'h80, 8'h9F, 8'h1F};
   logic [7:0] exp_tab [6] = '{8'h0F, 8'h17, 8'h9B, 8'h8C, 8'h1E, 8'h13};

   rcf_regs rcf_regs_i (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
      .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
      .i_pwdata(i_pwdata), .i_event(i_event),
      .i_brownout_enable_fuse(i_brownout_enable_fuse),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
      .o_interrupt_priority_enable(o_interrupt_priority_enable),
      .o_irq(o_irq));

   // 250 MHz system clock
   always #2 i_clock = ~i_clock;

   // hang guard
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen,
                      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s exp %h seen %h", what, exp, seen);
      end
   endtask

   // one apb transfer: setup, access held until pready at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clock);
      i_penable <= 1'b1;
      // wait for the answer; only the hang guard ends a lost one
      do begin
         @(posedge i_clock);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask

   // one-cycle event pulse, then let its edge land
   task automatic pulse(input logic [4:0] v);
      @(posedge i_clock);
      i_event <= rcf_event_t'(v);
      @(posedge i_clock);
      i_event <= rcf_event_t'(5'h00);
   endtask

   task automatic do_reset(input logic fuse);
      @(posedge i_clock);
      i_rst <= 1'b1;
      i_brownout_enable_fuse <= fuse;
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
   endtask

   // main sequence
   initial begin
      do_reset(1'b1);
      apb(1'b0, `RCF_OFS_FLAGS, 32'h0);
      chk("flags after power-on", rd, {24'h0, `RCF_FLAGS_POR_VAL | 8'h01});
      chk("interrupt_priority_enable after power-on", o_interrupt_priority_enable, 1'b0);
      apb(1'b1, `RCF_OFS_FLAGS, 32'hFFFF_FFFF);
      apb(1'b0, `RCF_OFS_FLAGS, 32'h0);
      chk("flags write all ones", rd, {24'h0, `RCF_FLAGS_WMASK});
      chk("interrupt_priority_enable output", o_interrupt_priority_enable, 1'b1);
      apb(1'b1, `RCF_OFS_FLAGS, 32'h0);
      apb(1'b0, `RCF_OFS_FLAGS, 32'h0);
      chk("flags write zero", rd, 32'h0);
      // each event source, plus expiry beating sleep and clear together
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `RCF_OFS_EVT_STATUS, 32'h1F);
         apb(1'b1, `RCF_OFS_FLAGS, {24'h0, pre_tab[i]});
         pulse(ev_tab[i]);
         apb(1'b0, `RCF_OFS_FLAGS, 32'h0);
         chk("flags after event", rd, {24'h0, exp_tab[i]});
         apb(1'b0, `RCF_OFS_EVT_STATUS, 32'h0);
         chk("event status", rd, {27'h0, ev_tab[i]});
         chk("irq masked", o_irq, 1'b0);
         apb(1'b1, `RCF_OFS_EVT_MASK, {27'h0, ev_tab[i]});
         apb(1'b0, `RCF_OFS_EVT_MASK, 32'h0);
         chk("event mask", rd, {27'h0, ev_tab[i]});
         chk("irq unmasked", o_irq, 1'b1);
         apb(1'b1, `RCF_OFS_EVT_STATUS, 32'h1F);
         apb(1'b0, `RCF_OFS_EVT_STATUS, 32'h0);
         chk("status cleared", rd, 32'h0);
         chk("irq after clear", o_irq, 1'b0);
         apb(1'b1, `RCF_OFS_EVT_MASK, 32'h0);
      end
      // software re-arms the power-on and brown-out flags
      apb(1'b1, `RCF_OFS_FLAGS, 32'h0000_0013);
      apb(1'b0, `RCF_OFS_FLAGS, 32'h0);
      chk("flags re-armed", rd, 32'h0000_0013);
      // unmapped place refuses and leaves flags alone
      apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
      chk("unmapped write err", err, 1'b1);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped read err", err, 1'b1);
      chk("unmapped read data", rd, 32'h0);
      apb(1'b0, `RCF_OFS_FLAGS, 32'h0);
      chk("flags after unmapped", rd, 32'h0000_0013);
      chk("mapped read err", err, 1'b0);
      // leave state behind that the next power-on must wipe
      apb(1'b1, `RCF_OFS_FLAGS, 32'h0000_00FF);
      apb(1'b1, `RCF_OFS_EVT_MASK, 32'h0000_001F);
      pulse(5'h04);
      apb(1'b0, `RCF_OFS_EVT_STATUS, 32'h0);
      chk("status before reset", rd, 32'h0000_0004);
      chk("irq before reset", o_irq, 1'b1);
      // power-on with brown-out fuse off
      do_reset(1'b0);
      apb(1'b0, `RCF_OFS_FLAGS, 32'h0);
      chk("flags fuse off", rd, {24'h0, `RCF_FLAGS_POR_VAL});
      chk("interrupt_priority_enable after reset", o_interrupt_priority_enable, 1'b0);
      apb(1'b0, `RCF_OFS_EVT_MASK, 32'h0);
      chk("mask after reset", rd, 32'h0);
      apb(1'b0, `RCF_OFS_EVT_STATUS, 32'h0);
      chk("status after reset", rd, 32'h0);
      chk("irq after reset", o_irq, 1'b0);
      finish_test();
   end
endmodule // testbench
